// >>> rtl/rpd_pkg.sv
// Package: constants and types of the rear-panel digital port
package rpd_pkg;

    // ==========================================================
    // Pin functions
    typedef enum logic [2:0] {
        RPD_FN_DIO      = 3'h0,
        RPD_FN_DIN      = 3'h1,
        RPD_FN_TRIG_OUT = 3'h2,
        RPD_FN_TRIG_IN  = 3'h3,
        RPD_FN_COUPLE   = 3'h4,
        RPD_FN_INHIBIT  = 3'h5
    } rpd_fn_t;

    // ==========================================================
    // Geometry
    localparam int unsigned NUM_PINS    = 3;
    localparam int unsigned INHIBIT_PIN = 2;

    // ==========================================================
    // Register map (byte addresses, word index = addr[5:2])
    localparam logic [3:0] IDX_FUNC     = 4'h0;
    localparam logic [3:0] IDX_POLARITY = 4'h1;
    localparam logic [3:0] IDX_OUT_BITS = 4'h2;
    localparam logic [3:0] IDX_IN_BITS  = 4'h3;
    localparam logic [3:0] IDX_LIST_CTL = 4'h4;
    localparam logic [3:0] IDX_STATUS   = 4'h5;

    // Field positions of FUNC: 3 bits per pin
    localparam int unsigned FN_W = 3;

    // Field positions of LIST_CTL
    localparam int unsigned LC_TRIG_SRC_BIT = 0;

    // Reset values
    localparam logic [8:0] FUNC_RST = 9'h000;
    localparam logic [2:0] POL_RST  = 3'h0;
    localparam logic [2:0] OUT_RST  = 3'h0;

    // Unmapped read answer
    localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;

    // ==========================================================
    // Timing
    localparam int unsigned CLK_MHZ          = 250;
    localparam int unsigned TRIG_PULSE_MS    = 5;
    localparam int unsigned TRIG_PULSE_CYC   = TRIG_PULSE_MS * 1000 * CLK_MHZ;
    localparam int unsigned PULSE_CNT_W      = 21;

endpackage : rpd_pkg

// >>> rtl/rpd_pin.sv
// Module: one rear-panel pin with synchroniser, polarity and pulse timer
`timescale 1ns/10ps
module rpd_pin #(
    parameter int unsigned PULSE_CYC = rpd_pkg::TRIG_PULSE_CYC
) (
    // Clock and reset
    input  wire logic                clk_sys,
    input  wire logic                sys_rst,
    // Configuration
    input  wire logic [2:0]          func,
    input  wire logic                pol_neg,
    input  wire logic                out_bit,
    // Trigger request from the sequencer
    input  wire logic                fire,
    // Pin
    input  wire logic                pin_i,
    output logic                     pin_o,
    output logic                     pin_oe_n,
    // Status
    output logic                     in_bit,
    output logic                     edge_seen
);

    // ==========================================================
    // State
    logic                      sync1_r, sync1_nxt;
    logic                      sync2_r, sync2_nxt;
    logic                      prev_r,  prev_nxt;
    logic [rpd_pkg::PULSE_CNT_W-1:0] cnt_r, cnt_nxt;
    logic                      pin_o_r, pin_o_nxt;
    logic                      oe_n_r,  oe_n_nxt;
    logic                      in_r,    in_nxt;
    logic                      edge_r,  edge_nxt;
    logic                      eff_neg;
    logic                      drives;

    always_comb begin
        // Coupling pin polarity is fixed negative
        eff_neg   = (func == rpd_pkg::RPD_FN_COUPLE) ? 1'b1 : pol_neg;
        sync1_nxt = pin_i;
        sync2_nxt = sync1_r;
        prev_nxt  = sync2_r;
        in_nxt    = sync2_r ^ eff_neg;
        edge_nxt  = (sync2_r != prev_r);
        cnt_nxt   = cnt_r;
        if (func == rpd_pkg::RPD_FN_TRIG_OUT) begin
            if (fire) begin
                cnt_nxt = PULSE_CYC[rpd_pkg::PULSE_CNT_W-1:0];
            end else if (cnt_r != '0) begin
                cnt_nxt = cnt_r - 1'b1;
            end
        end else begin
            cnt_nxt = '0;
        end
        drives = (func == rpd_pkg::RPD_FN_DIO) || (func == rpd_pkg::RPD_FN_TRIG_OUT);
        oe_n_nxt = ~drives;
        if (func == rpd_pkg::RPD_FN_TRIG_OUT) begin
            pin_o_nxt = (cnt_nxt != '0) ^ eff_neg;
        end else begin
            pin_o_nxt = out_bit ^ eff_neg;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            prev_r  <= 1'b0;
            cnt_r   <= '0;
            pin_o_r <= 1'b0;
            oe_n_r  <= 1'b1;
            in_r    <= 1'b0;
            edge_r  <= 1'b0;
        end else begin
            sync1_r <= sync1_nxt;
            sync2_r <= sync2_nxt;
            prev_r  <= prev_nxt;
            cnt_r   <= cnt_nxt;
            pin_o_r <= pin_o_nxt;
            oe_n_r  <= oe_n_nxt;
            in_r    <= in_nxt;
            edge_r  <= edge_nxt;
        end
    end

    assign pin_o     = pin_o_r;
    assign pin_oe_n  = oe_n_r;
    assign in_bit    = in_r;
    assign edge_seen = edge_r;

endmodule // rpd_pin

// >>> rtl/rpd_port.sv
// Module: top of the three-pin rear-panel digital port with Avalon-MM registers
//
// Behaviour
// - Three pins, each one selected function
// - Digital I/O pins read and drive
// - Pin3 bit2 msb, Pin1 bit0 lsb
// - Per-pin polarity on input and output
// - Digital input senses only, never drives
// - Trigger output pulse about five milliseconds
// - Pulse high if positive, low if negative
// - Pulses only at marked list steps
// - One pulse per marked step while running
// - Trigger input edge advances list when selected
// - Trigger and inhibit inputs report relative level
// - At most one coupling pin
// - Coupling pin polarity forced negative
// - Coupling pin edge toggles coupled outputs
// - Inhibit only on third pin
`timescale 1ns/10ps
module rpd_port #(
    parameter int unsigned PULSE_CYC = rpd_pkg::TRIG_PULSE_CYC
) (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    // Avalon-MM slave
    input  wire logic [5:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    // List sequencer
    input  wire logic        list_running,
    input  wire logic        step_begin,
    input  wire logic        step_end,
    input  wire logic        step_begin_marker,
    input  wire logic        step_end_marker,
    output logic             list_trigger,
    // Output coupling and inhibit
    output logic             couple_toggle,
    output logic             inhibit_active,
    // Pins
    input  wire logic [2:0]  pin_i,
    output logic [2:0]       pin_o,
    output logic [2:0]       pin_oe_n
);

    // ==========================================================
    // Registers
    logic [8:0]  func_r,   func_nxt;
    logic [2:0]  pol_r,    pol_nxt;
    logic [2:0]  out_r,    out_nxt;
    logic        src_r,    src_nxt;
    logic        rej_r,    rej_nxt;
    logic [31:0] rdata_r,  rdata_nxt;
    logic        wait_r,   wait_nxt;
    logic        ltrig_r,  ltrig_nxt;
    logic        ctog_r,   ctog_nxt;
    logic        inh_r,    inh_nxt;

    logic [2:0]  in_bits;
    logic [2:0]  edges;
    logic        fire;
    logic [3:0]  idx;
    logic        access;
    logic [8:0]  wfunc;
    logic        wfunc_ok;
    logic [1:0]  n_couple;

    assign idx    = avs_address[5:2];
    assign access = (avs_read || avs_write) && wait_r;

    // ==========================================================
    // Trigger request from marked list steps
    assign fire = list_running && ((step_begin && step_begin_marker)
                                || (step_end && step_end_marker));

    // ==========================================================
    // Pins
    genvar g;
    generate
        for (g = 0; g < rpd_pkg::NUM_PINS; g++) begin : g_pin
            rpd_pin #(
                .PULSE_CYC (PULSE_CYC)
            ) u_pin (
                .clk_sys   (clk_sys),
                .sys_rst   (sys_rst),
                .func      (func_r[g*rpd_pkg::FN_W +: rpd_pkg::FN_W]),
                .pol_neg   (pol_r[g]),
                .out_bit   (out_r[g]),
                .fire      (fire),
                .pin_i     (pin_i[g]),
                .pin_o     (pin_o[g]),
                .pin_oe_n  (pin_oe_n[g]),
                .in_bit    (in_bits[g]),
                .edge_seen (edges[g])
            );
        end
    endgenerate

    // ==========================================================
    // Function write check
    always_comb begin
        wfunc    = func_r;
        if (avs_byteenable[0]) begin
            wfunc[7:0] = avs_writedata[7:0];
        end
        if (avs_byteenable[1]) begin
            wfunc[8] = avs_writedata[8];
        end
        wfunc_ok = 1'b1;
        n_couple = 2'h0;
        for (int i = 0; i < rpd_pkg::NUM_PINS; i++) begin
            if (wfunc[i*rpd_pkg::FN_W +: rpd_pkg::FN_W] > rpd_pkg::RPD_FN_INHIBIT) begin
                wfunc_ok = 1'b0;
            end
            if (wfunc[i*rpd_pkg::FN_W +: rpd_pkg::FN_W] == rpd_pkg::RPD_FN_COUPLE) begin
                n_couple = n_couple + 2'h1;
            end
            if ((i != rpd_pkg::INHIBIT_PIN)
                && (wfunc[i*rpd_pkg::FN_W +: rpd_pkg::FN_W] == rpd_pkg::RPD_FN_INHIBIT)) begin
                wfunc_ok = 1'b0;
            end
        end
        if (n_couple > 2'h1) begin
            wfunc_ok = 1'b0;
        end
    end

    // ==========================================================
    // Register file and bus
    always_comb begin
        func_nxt  = func_r;
        pol_nxt   = pol_r;
        out_nxt   = out_r;
        src_nxt   = src_r;
        rej_nxt   = rej_r;
        rdata_nxt = rdata_r;
        wait_nxt  = 1'b1;
        if (access) begin
            wait_nxt = 1'b0;
            if (avs_write) begin
                unique case (idx)
                    rpd_pkg::IDX_FUNC: begin
                        if (wfunc_ok) begin
                            func_nxt = wfunc;
                            rej_nxt  = 1'b0;
                        end else begin
                            rej_nxt = 1'b1;
                        end
                    end
                    rpd_pkg::IDX_POLARITY: begin
                        if (avs_byteenable[0]) begin
                            pol_nxt = avs_writedata[2:0];
                        end
                    end
                    rpd_pkg::IDX_OUT_BITS: begin
                        if (avs_byteenable[0]) begin
                            out_nxt = avs_writedata[2:0];
                        end
                    end
                    rpd_pkg::IDX_LIST_CTL: begin
                        if (avs_byteenable[0]) begin
                            src_nxt = avs_writedata[rpd_pkg::LC_TRIG_SRC_BIT];
                        end
                    end
                    default: begin
                    end
                endcase
                rdata_nxt = rpd_pkg::RD_UNMAPPED;
            end else begin
                unique case (idx)
                    rpd_pkg::IDX_FUNC:     rdata_nxt = {23'h0, func_r};
                    rpd_pkg::IDX_POLARITY: rdata_nxt = {29'h0, pol_r};
                    rpd_pkg::IDX_OUT_BITS: rdata_nxt = {29'h0, out_r};
                    rpd_pkg::IDX_IN_BITS:  rdata_nxt = {29'h0, in_bits};
                    rpd_pkg::IDX_LIST_CTL: rdata_nxt = {31'h0, src_r};
                    rpd_pkg::IDX_STATUS:   rdata_nxt = {31'h0, rej_r};
                    default:               rdata_nxt = rpd_pkg::RD_UNMAPPED;
                endcase
            end
        end
    end

    // ==========================================================
    // Events toward the sequencer and outputs
    always_comb begin
        ltrig_nxt = 1'b0;
        ctog_nxt  = 1'b0;
        for (int i = 0; i < rpd_pkg::NUM_PINS; i++) begin
            if (edges[i] && (func_r[i*rpd_pkg::FN_W +: rpd_pkg::FN_W] == rpd_pkg::RPD_FN_TRIG_IN)
                && src_r && list_running) begin
                ltrig_nxt = 1'b1;
            end
            if (edges[i] && (func_r[i*rpd_pkg::FN_W +: rpd_pkg::FN_W] == rpd_pkg::RPD_FN_COUPLE)) begin
                ctog_nxt = 1'b1;
            end
        end
        inh_nxt = (func_r[rpd_pkg::INHIBIT_PIN*rpd_pkg::FN_W +: rpd_pkg::FN_W]
                   == rpd_pkg::RPD_FN_INHIBIT) && in_bits[rpd_pkg::INHIBIT_PIN];
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            func_r  <= rpd_pkg::FUNC_RST;
            pol_r   <= rpd_pkg::POL_RST;
            out_r   <= rpd_pkg::OUT_RST;
            src_r   <= 1'b0;
            rej_r   <= 1'b0;
            rdata_r <= rpd_pkg::RD_UNMAPPED;
            wait_r  <= 1'b1;
            ltrig_r <= 1'b0;
            ctog_r  <= 1'b0;
            inh_r   <= 1'b0;
        end else begin
            func_r  <= func_nxt;
            pol_r   <= pol_nxt;
            out_r   <= out_nxt;
            src_r   <= src_nxt;
            rej_r   <= rej_nxt;
            rdata_r <= rdata_nxt;
            wait_r  <= wait_nxt;
            ltrig_r <= ltrig_nxt;
            ctog_r  <= ctog_nxt;
            inh_r   <= inh_nxt;
        end
    end

    assign avs_readdata    = rdata_r;
    assign avs_waitrequest = wait_r;
    assign list_trigger    = ltrig_r;
    assign couple_toggle   = ctog_r;
    assign inhibit_active  = inh_r;

endmodule // rpd_port

// >>> dv/rpd_port_chk.sv
// Checker: bus answer and pin event assertions of the rear-panel port
`timescale 1ns/10ps
module rpd_port_chk (
    // Clock and reset
    input wire logic        clk_sys,
    input wire logic        sys_rst,
    // Register bus
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    // Events and pins
    input wire logic        list_running,
    input wire logic        list_trigger,
    input wire logic        couple_toggle,
    input wire logic [2:0]  pin_i
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    // ==========
    // Assertions
    ans_wait_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus answer late");
    ans_short_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("answer too long");
    ans_cause_a: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
        else $error("answer without request");
    rd_hold_a: assert property ($changed(avs_readdata) |-> !avs_waitrequest)
        else $error("read data moved");
    trig_cause_a: assert property (list_trigger |-> $past(pin_i, 4) != $past(pin_i, 5))
        else $error("trigger without edge");
    trig_single_a: assert property (list_trigger |=> !list_trigger)
        else $error("trigger too long");
    trig_run_a: assert property (list_trigger |-> $past(list_running))
        else $error("trigger while idle");
    cpl_cause_a: assert property (couple_toggle |-> $past(pin_i, 4) != $past(pin_i, 5))
        else $error("toggle without edge");
    cpl_single_a: assert property (couple_toggle |=> !couple_toggle)
        else $error("toggle too long");
    // ==========
    // Covers
    cover property (list_trigger);
    cover property (couple_toggle);
    cover property (avs_read && !avs_waitrequest);
endmodule // rpd_port_chk

// >>> dv/rpd_ext_equip.sv
// Model: external equipment applying levels on the three rear-panel pins
`timescale 1ns/10ps
module rpd_ext_equip (
    // Levels set by the equipment
    input wire logic [2:0] ext_lvl,
    // Device side
    input wire logic [2:0] pin_o,
    input wire logic [2:0] pin_oe_n,
    output logic [2:0]     pin_i
);
    // Device drive wins; a released pin shows the equipment level
    assign pin_i = (pin_oe_n & ext_lvl) | (~pin_oe_n & pin_o);
endmodule // rpd_ext_equip

// >>> dv/rear_panel_digital_io_tb.sv
// Testbench: rear-panel port against a behavioural model
`timescale 1ns/10ps
module rear_panel_digital_io_tb;
    localparam int PC = 20;
    localparam logic [5:0] A_FN = 6'h00, A_POL = 6'h04, A_OUT = 6'h08;
    localparam logic [5:0] A_IN = 6'h0C, A_LC = 6'h10, A_ST = 6'h14;
    logic        clk_sys = '0, sys_rst = 1'h1, avs_read = '0, avs_write = '0;
    logic [5:0]  avs_address = '0;
    logic [31:0] avs_writedata = '0, avs_readdata, q;
    logic [3:0]  avs_byteenable = 4'hF;
    logic        avs_waitrequest, list_running = '0, step_begin = '0, step_end = '0;
    logic        step_begin_marker = '0, step_end_marker = '0;
    logic        list_trigger, couple_toggle, inhibit_active;
    logic [2:0]  pin_i, pin_o, pin_oe_n, ext_lvl = '0, pol, lvl;
    logic [31:0] bad [4] = '{32'h5, 32'h28, 32'h24, 32'h38};
    int          n_mismatch = 0, tests_run = 0, n_lt = 0, n_ct = 0, b;
    int          seed = 32'hB6EB;

    always #2 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        n_lt <= n_lt + (list_trigger === 1'h1);
        n_ct <= n_ct + (couple_toggle === 1'h1);
    end

    rpd_port #(.PULSE_CYC(PC)) dut (.clk_sys, .sys_rst, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .list_running,
        .step_begin, .step_end, .step_begin_marker, .step_end_marker, .list_trigger,
        .couple_toggle, .inhibit_active, .pin_i, .pin_o, .pin_oe_n);
    rpd_ext_equip eq (.ext_lvl, .pin_o, .pin_oe_n, .pin_i);

    // ==========
    // Tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge clk_sys);
        end while (avs_waitrequest !== 1'h0);
        q = avs_readdata;
        avs_write <= 1'h0;
        avs_read <= 1'h0;
        @(posedge clk_sys);
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        bus(1'h1, a, d);
    endtask
    task automatic rdc(input logic [5:0] a, input logic [31:0] exp);
        bus(1'h0, a, 32'h0);
        chk(q, exp);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic pulse(input logic sb, se, mb, me, input int len);
        int hi, lo;
        hi = 0;
        lo = 0;
        step_begin <= sb;
        step_end <= se;
        step_begin_marker <= mb;
        step_end_marker <= me;
        @(posedge clk_sys);
        step_begin <= 1'h0;
        step_end <= 1'h0;
        repeat (PC + 8) begin
            @(posedge clk_sys);
            hi += (pin_o[0] === 1'h1);
            lo += (pin_o[2] === 1'h0);
        end
        chk(32'(hi), 32'(len));
        chk(32'(lo), 32'(len));
    endtask
    task automatic conclude();
        $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ==========
    // Scenarios
    initial begin
        cyc(4);
        sys_rst <= 1'h0;
        for (int a = 0; a < 8; a++) rdc(6'(a * 4), 32'h0);
        repeat (6) begin
            lvl = 3'($random(seed));
            pol = 3'($random(seed));
            wr(A_POL, 32'(pol));
            wr(A_OUT, 32'(lvl));
            cyc(2);
            chk(32'(pin_o), 32'(lvl ^ pol));
            chk(32'(pin_oe_n), 32'h0);
            rdc(A_IN, 32'(lvl));
        end
        wr(A_FN, 32'h49);
        repeat (4) begin
            lvl = 3'($random(seed));
            pol = 3'($random(seed));
            ext_lvl <= lvl;
            wr(A_POL, 32'(pol));
            cyc(2);
            chk(32'(pin_oe_n), 32'h7);
            rdc(A_IN, 32'(lvl ^ pol));
        end
        foreach (bad[i]) begin
            wr(A_FN, bad[i]);
            rdc(A_ST, 32'h1);
            rdc(A_FN, 32'h49);
        end
        wr(A_POL, 32'h0);
        wr(A_OUT, 32'h0);
        wr(A_FN, 32'h20);
        rdc(A_ST, 32'h0);
        cyc(8);
        repeat (2) begin
            b = n_ct;
            ext_lvl[1] <= ~ext_lvl[1];
            cyc(10);
            chk(32'(n_ct - b), 32'h1);
            rdc(A_IN, 32'({1'h0, ~ext_lvl[1], 1'h0}));
        end
        list_running <= 1'h1;
        wr(A_FN, 32'h3);
        wr(A_LC, 32'h1);
        cyc(8);
        for (int k = 0; k < 4; k++) begin
            if (k == 3) wr(A_LC, 32'h0);
            b = n_lt;
            ext_lvl[0] <= ~ext_lvl[0];
            cyc(10);
            chk(32'(n_lt - b), 32'(k < 3));
            rdc(A_IN, 32'(ext_lvl[0]));
        end
        wr(A_FN, 32'h140);
        repeat (4) begin
            lvl = 3'($random(seed));
            pol = 3'($random(seed));
            ext_lvl <= lvl;
            wr(A_POL, 32'(pol));
            cyc(6);
            chk(32'(inhibit_active), 32'(lvl[2] ^ pol[2]));
            rdc(A_IN, {29'h0, lvl[2] ^ pol[2], 2'h0});
        end
        wr(A_FN, 32'h82);
        wr(A_POL, 32'h4);
        cyc(4);
        chk(32'({pin_o[2], pin_o[0]}), 32'h2);
        pulse(1'h1, 1'h0, 1'h1, 1'h0, PC);
        pulse(1'h0, 1'h1, 1'h1, 1'h0, 0);
        pulse(1'h0, 1'h1, 1'h0, 1'h1, PC);
        list_running <= 1'h0;
        pulse(1'h1, 1'h0, 1'h1, 1'h0, 0);
        conclude();
    end

    initial begin
        #40000;
        n_mismatch++;
        conclude();
    end
endmodule // rear_panel_digital_io_tb

bind rpd_port rpd_port_chk chk_i (.clk_sys, .sys_rst, .avs_read, .avs_write, .avs_readdata,
    .avs_waitrequest, .list_running, .list_trigger, .couple_toggle, .pin_i);
